// *** src/sci_sync_pkg.sv ***
package sci_sync_pkg;
    // mode selection
    localparam logic [2:0] WORD_SELECT_SYNC = 3'h0;
    localparam logic       CLK_SRC_INTERNAL = 1'h0;
    localparam logic       CLK_SRC_EXTERNAL = 1'h1;

    // timing, clock_i at 250 MHz
    localparam int CLOCK_PERIOD_PS   = 4000;
    localparam int MASTER_BIT_PS     = 32000;
    localparam int CRYSTAL_PERIOD_PS = 4000;
    localparam int TAIL_HOLD_PS      = (CRYSTAL_PERIOD_PS * 3) / 2;
    localparam int BIT_CYCLES        = MASTER_BIT_PS / CLOCK_PERIOD_PS;
    localparam int TAIL_CYCLES       = (TAIL_HOLD_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

    localparam logic [2:0] PHASE_SAMPLE = 3'(BIT_CYCLES / 4);
    localparam logic [2:0] PHASE_HALF   = 3'(BIT_CYCLES / 2);
    localparam logic [2:0] PHASE_LAST   = 3'(BIT_CYCLES - 1);
    localparam logic [1:0] TAIL_COUNT   = 2'(TAIL_CYCLES);

    // bit positions within a word
    localparam logic [2:0] BIT_FIRST       = 3'h0;
    localparam logic [2:0] BIT_EMPTY_SET   = 3'h1;
    localparam logic [2:0] BIT_NEXT_DECIDE = 3'h6;
    localparam logic [2:0] BIT_LAST        = 3'h7;

    // reset values
    localparam logic       TXD_IDLE   = 1'h1;
    localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] async_i,
    output logic      [1:0] sync_o
);
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // first stage is read only by the second stage
    always_comb begin
        next_st        = st;
        next_st.meta   = async_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;
endmodule

// *** src/sci_sync_shift.sv ***
`timescale 1ns/100ps
// Functional notes
// - word select zero enables shift mode
// - one clock serves transmit and receive
// - master clocks only while word present
// - both sources internal selects master
// - both sources external selects slave
// - master starts on full hold register, eight bits
// - master bit stable across both edges
// - master samples mid low or high
// - empty flag sets mid bit one
// - slave edges follow clock polarity
// - no frame, misalignment unflagged
// - slave last bit truncated, pin idles
// - wired-or releases idle transmit pin
// - late slave write causes retransmission
// - slave shifting follows external clock
// - preloaded slave byte goes out first
// - write clears empty, mid bit one sets it
// - reading receive data clears full flag
module sci_sync_shift (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] word_select_field_i,
    input  wire logic       clock_polarity_bit_i,
    input  wire logic       transmit_clock_source_i,
    input  wire logic       receive_clock_source_i,
    input  wire logic       wired_or_select_i,
    input  wire logic       tx_write_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       rx_read_i,
    input  wire logic       sclk_i,
    input  wire logic       rxd_i,
    output logic            sclk_o,
    output logic            sclk_oe_o,
    output logic            txd_o,
    output logic            txd_oe_o,
    output logic      [7:0] receive_data_reg_o,
    output logic            receive_full_flag_o,
    output logic            transmit_empty_flag_o
);
    import sci_sync_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP} run_t;

    typedef struct packed {
        run_t       state;
        logic [7:0] tx_hold;
        logic       hold_full;
        logic       fresh;
        logic       next_ok;
        logic [7:0] tx_word;
        logic [2:0] bit_idx;
        logic [2:0] phase;
        logic [2:0] drive_idx;
        logic [1:0] tail_cnt;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic       rx_full;
        logic       sclk_prev;
        logic       sclk_out;
        logic       sclk_oe;
        logic       txd_out;
        logic       txd_oe;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic [1:0]  synced;
    logic        sclk_s;
    logic        rxd_s;
    logic        sync_mode;
    logic        master;
    logic        slave;
    logic        rise;
    logic        fall;
    logic        capture;
    logic        drive;
    logic        mid_bit;
    logic        rx_done;
    logic        transmitting;

    function automatic logic edge_pick(input logic falling_sel, input logic r, input logic f);
        edge_pick = falling_sel ? f : r;
    endfunction

    pin_sync u_pin_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({sclk_i, rxd_i}),
        .sync_o  (synced)
    );

    assign sclk_s    = synced[1];
    assign rxd_s     = synced[0];
    assign sync_mode = word_select_field_i == WORD_SELECT_SYNC;
    assign master    = sync_mode && transmit_clock_source_i == CLK_SRC_INTERNAL
                       && receive_clock_source_i == CLK_SRC_INTERNAL;
    assign slave     = sync_mode && transmit_clock_source_i == CLK_SRC_EXTERNAL
                       && receive_clock_source_i == CLK_SRC_EXTERNAL;
    assign rise      = sclk_s && !st.sclk_prev;
    assign fall      = !sclk_s && st.sclk_prev;
    assign capture   = edge_pick(clock_polarity_bit_i, rise, fall);
    assign drive     = edge_pick(!clock_polarity_bit_i, rise, fall);

    always_comb begin
        next_st           = st;
        next_st.sclk_prev = sclk_s;
        mid_bit           = 1'b0;
        rx_done           = 1'b0;
        transmitting      = 1'b0;
        if (master) begin
            unique case (st.state)
                ST_IDLE: begin
                    next_st.phase   = 3'h0;
                    next_st.bit_idx = BIT_FIRST;
                    if (st.hold_full) begin
                        next_st.tx_word = st.tx_hold;
                        next_st.fresh   = 1'b1;
                        next_st.state   = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    next_st.phase = st.phase + 3'h1;
                    // sample at quarter phase: middle of first clock half
                    if (st.phase == PHASE_SAMPLE) begin
                        next_st.rx_shift = {rxd_s, st.rx_shift[7:1]};
                        rx_done          = st.bit_idx == BIT_LAST;
                    end
                    mid_bit = st.phase == PHASE_HALF;
                    if (st.phase == PHASE_LAST) begin
                        if (st.bit_idx != BIT_LAST) begin
                            next_st.bit_idx = st.bit_idx + 3'h1;
                        end else if (st.next_ok) begin
                            next_st.tx_word = st.tx_hold;
                            next_st.fresh   = 1'b1;
                            next_st.bit_idx = BIT_FIRST;
                        end else begin
                            // late write: gap, then restart from idle
                            next_st.state = ST_IDLE;
                        end
                    end
                end
                ST_TAIL, ST_GAP: begin
                    next_st.state = ST_IDLE;
                end
            endcase
        end else if (slave) begin
            // shifting only on received edges; no edges, no progress
            if (capture) begin
                next_st.rx_shift = {rxd_s, st.rx_shift[7:1]};
                next_st.bit_idx  = st.bit_idx + 3'h1;
                rx_done          = st.bit_idx == BIT_LAST;
                mid_bit          = 1'b1;
            end
            // bit count runs free; a lost edge shifts alignment for good
            unique case (st.state)
                ST_IDLE: begin
                    if (st.hold_full && st.bit_idx == BIT_FIRST) begin
                        next_st.tx_word   = st.tx_hold;
                        next_st.fresh     = 1'b1;
                        next_st.drive_idx = BIT_FIRST;
                        next_st.state     = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (drive) begin
                        next_st.drive_idx = st.bit_idx;
                    end
                    if (capture && st.bit_idx == BIT_LAST) begin
                        next_st.tail_cnt = TAIL_COUNT;
                        next_st.state    = ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    next_st.tail_cnt = st.tail_cnt - 2'h1;
                    if (st.tail_cnt == 2'h1) begin
                        next_st.state = ST_GAP;
                        if (st.next_ok) begin
                            next_st.tx_word = st.tx_hold;
                            next_st.fresh   = 1'b1;
                        end
                        // else tx_word kept: same word goes out again
                    end
                end
                ST_GAP: begin
                    if (drive) begin
                        next_st.drive_idx = BIT_FIRST;
                        next_st.state     = ST_SHIFT;
                    end
                end
            endcase
        end else begin
            // mixed sources are undefined; hold still
            next_st.state = ST_IDLE;
        end

        if (mid_bit && st.state != ST_IDLE) begin
            if (st.bit_idx == BIT_EMPTY_SET && st.fresh) begin
                next_st.hold_full = 1'b0;
                next_st.fresh     = 1'b0;
            end
            if (st.bit_idx == BIT_NEXT_DECIDE) begin
                next_st.next_ok = st.hold_full;
            end
        end
        // write after the clear so a same-cycle write is kept
        if (tx_write_i) begin
            next_st.tx_hold   = tx_data_i;
            next_st.hold_full = 1'b1;
        end
        if (rx_done) begin
            next_st.rx_data = next_st.rx_shift;
            next_st.rx_full = 1'b1;
        end else if (rx_read_i) begin
            next_st.rx_full = 1'b0;
        end

        transmitting = next_st.state == ST_SHIFT
                       || (slave && next_st.state == ST_TAIL);
        next_st.txd_out = TXD_IDLE;
        if (transmitting) begin
            next_st.txd_out = next_st.tx_word[master ? next_st.bit_idx : next_st.drive_idx];
        end
        next_st.txd_oe  = (master || slave) && (!wired_or_select_i || transmitting);
        next_st.sclk_oe = master;
        next_st.sclk_out = !clock_polarity_bit_i;
        if (master && next_st.state == ST_SHIFT && next_st.phase < PHASE_HALF) begin
            next_st.sclk_out = clock_polarity_bit_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st          <= '0;
            st.state    <= ST_IDLE;
            st.tx_hold  <= DATA_RESET;
            st.tx_word  <= DATA_RESET;
            st.rx_data  <= DATA_RESET;
            st.sclk_out <= 1'b1;
            st.txd_out  <= TXD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign sclk_o                = st.sclk_out;
    assign sclk_oe_o             = st.sclk_oe;
    assign txd_o                 = st.txd_out;
    assign txd_oe_o              = st.txd_oe;
    assign receive_data_reg_o    = st.rx_data;
    assign receive_full_flag_o   = st.rx_full;
    assign transmit_empty_flag_o = !st.hold_full;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_bit1_mid;
        master && st.state == ST_SHIFT && st.bit_idx == BIT_EMPTY_SET
        && st.phase == PHASE_HALF && st.fresh && !tx_write_i;
    endsequence

    sequence s_tail_enter;
        slave && st.state == ST_SHIFT && capture && st.bit_idx == BIT_LAST;
    endsequence

    AST_MODE_OFF: assert property (!sync_mode |=> st.state == ST_IDLE && !sclk_oe_o)
        else $error("shift engine active outside synchronous mode");
    AST_GATED_CLOCK: assert property (master && st.state == ST_IDLE && !st.hold_full
        && $stable(clock_polarity_bit_i) |=> sclk_o == !clock_polarity_bit_i)
        else $error("master clock toggled with no word");
    AST_MASTER_SEL: assert property (master |=> sclk_oe_o)
        else $error("master not driving clock");
    AST_SLAVE_SEL: assert property (slave |=> !sclk_oe_o)
        else $error("slave driving clock pin");
    AST_MASTER_START: assert property (master && st.state == ST_IDLE && st.hold_full
        |=> st.state == ST_SHIFT ##1 sclk_o == clock_polarity_bit_i)
        else $error("master did not start on loaded word");
    AST_BIT_STABLE: assert property (master && st.state == ST_SHIFT
        && st.phase != PHASE_LAST |=> $stable(txd_o))
        else $error("master data moved inside a bit");
    AST_EMPTY_MID1: assert property (s_bit1_mid |=> transmit_empty_flag_o)
        else $error("empty flag not set at bit one middle");
    AST_WRITE_CLEARS: assert property (tx_write_i |=> !transmit_empty_flag_o)
        else $error("write did not clear empty flag");
    AST_RX_FULL: assert property (rx_done |=> receive_full_flag_o
        && receive_data_reg_o == $past(next_st.rx_shift))
        else $error("received byte not latched");
    AST_READ_CLEARS: assert property (rx_read_i && !rx_done |=> !receive_full_flag_o)
        else $error("read did not clear full flag");
    AST_TAIL_LEN: assert property (s_tail_enter |=> (st.state == ST_TAIL) [*2]
        ##1 st.state == ST_GAP)
        else $error("last bit tail wrong length");
    AST_WIRED_OR: assert property (wired_or_select_i && st.state == ST_IDLE
        && next_st.state == ST_IDLE |=> !txd_oe_o)
        else $error("idle transmit pin still driven");
endmodule

// *** tb/sync_partner.sv ***
`timescale 1ns/100ps
module sync_partner (
    input  wire logic       dut_sclk_i,
    input  wire logic       dut_sclk_oe_i,
    input  wire logic       txd_i,
    output logic            sclk_o,
    output logic            rxd_o,
    output logic      [7:0] got_o,
    output int              edges_o
);
    logic [7:0] out_shift = 8'h00;
    logic       phase     = 1'b0;
    logic       rest      = 1'b0;
    initial begin
        rxd_o   = 1'b0;
        got_o   = 8'h00;
        edges_o = 0;
    end
    // rests at polarity level between frames, first edge captures
    assign sclk_o = rest ^ phase;
    task automatic take;
        got_o = {txd_i, got_o[7:1]};
        edges_o++;
    endtask
    // shifts in inverted bits, so consecutive bytes always differ
    task automatic shift_out;
        out_shift = {~out_shift[0], out_shift[7:1]};
        rxd_o = out_shift[0];
    endtask
    task automatic load(input logic [7:0] b, input logic r);
        rest = r;
        out_shift = b;
        rxd_o = b[0];
        edges_o = 0;
        phase = 1'b0;
    endtask
    // data only changes on the drive edge, half a period before capture
    task automatic run(input int bits);
        repeat (bits) begin
            #24 phase = 1'b1;
            take();
            #24 phase = 1'b0;
            shift_out();
        end
    endtask
    // shift register fed by the gated clock; also drives the data line on each take
    always @(dut_sclk_i) begin
        if (dut_sclk_oe_i && dut_sclk_i !== rest) begin
            take();
            shift_out();
        end
    end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
    import sci_sync_pkg::*;
    logic       clock_i = 1'b0;
    logic       rst_i   = 1'b1;
    logic [2:0] ws      = WORD_SELECT_SYNC;
    logic       pol     = 1'b0;
    logic       transmit_clock_source     = 1'b0;
    logic       receive_clock_source     = 1'b0;
    logic       wom     = 1'b0;
    logic       tx_write = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       rx_read = 1'b0;
    logic       sclk_o, sclk_oe_o, txd_o, txd_oe_o, full, empty, p_sclk, p_rxd;
    logic [7:0] rx_data, p_got;
    int         p_edges, cyc;
    int         miscompares = 0;
    int         checks_done = 0;
    time        t0;
    wire        sclk_wire = transmit_clock_source ? p_sclk : sclk_o;
    wire        txd_wire  = txd_oe_o ? txd_o : 1'b1;

    always #2 clock_i = ~clock_i;

    sci_sync_shift u_sci_sync_shift (.clock_i(clock_i), .rst_i(rst_i), .word_select_field_i(ws),
        .clock_polarity_bit_i(pol), .transmit_clock_source_i(transmit_clock_source), .receive_clock_source_i(receive_clock_source),
        .wired_or_select_i(wom), .tx_write_i(tx_write), .tx_data_i(tx_data), .rx_read_i(rx_read),
        .sclk_i(sclk_wire), .rxd_i(p_rxd), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .txd_o(txd_o),
        .txd_oe_o(txd_oe_o), .receive_data_reg_o(rx_data), .receive_full_flag_o(full),
        .transmit_empty_flag_o(empty));
    sync_partner u_sync_partner (.dut_sclk_i(sclk_wire),
        .dut_sclk_oe_i(sclk_oe_o), .txd_i(txd_wire), .sclk_o(p_sclk), .rxd_o(p_rxd), .got_o(p_got),
        .edges_o(p_edges));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // a fresh reset per scenario also restores word alignment
    task automatic start(input logic [2:0] w, input logic t, input logic r, input logic p, input logic o);
        rst_i = 1'b1;
        ws = w;
        transmit_clock_source = t;
        receive_clock_source = r;
        pol = p;
        wom = o;
        // rest level moves inside reset, so no stray edge reaches a running block
        u_sync_partner.load(8'h00, p);
        tick(10);
        rst_i = 1'b0;
        tick(1);
        u_sync_partner.load(8'h00, p);
    endtask
    task automatic write_byte(input logic [7:0] b);
        tx_write = 1'b1;
        tx_data = b;
        tick(1);
        tx_write = 1'b0;
    endtask
    task automatic wait_edges(input int n);
        cyc = 0;
        while (p_edges < n && cyc < 400) begin
            tick(1);
            cyc++;
        end
        check(8'(p_edges), 8'(n));
    endtask
    task automatic read_byte(input logic [7:0] exp);
        cyc = 0;
        while (full !== 1'b1 && cyc < 400) begin
            tick(1);
            cyc++;
        end
        check(rx_data, exp);
        rx_read = 1'b1;
        tick(1);
        rx_read = 1'b0;
        check({7'h0, full}, 8'h00);
    endtask
    task automatic complete_run;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    initial begin
        for (int p = 0; p < 2; p++) begin
            start(WORD_SELECT_SYNC, CLK_SRC_INTERNAL, CLK_SRC_INTERNAL, p[0], 1'b1);
            check({4'h0, empty, full, txd_o, txd_oe_o}, 8'h0a);
            u_sync_partner.load(8'h96, pol);
            tick(20);
            check(8'(p_edges), 8'h00);
            write_byte(8'h3c);
            check({7'h0, empty}, 8'h00);
            wait_edges(1);
            check({7'h0, empty}, 8'h00);
            wait_edges(3);
            check({7'h0, empty}, 8'h01);
            write_byte(8'ha5);
            wait_edges(8);
            t0 = $time;
            check(p_got, 8'h3c);
            read_byte(8'h96);
            wait_edges(16);
            check(8'(($time - t0) / 4), 8'd64);
            check(p_got, 8'ha5);
            read_byte(8'h69);
            tick(40);
            check(8'(p_edges), 8'd16);
            check({7'h0, txd_oe_o}, 8'h00);
        end
        for (int p = 0; p < 2; p++) begin
            start(WORD_SELECT_SYNC, CLK_SRC_EXTERNAL, CLK_SRC_EXTERNAL, p[0], p[0]);
            check({7'h0, txd_oe_o}, {7'h0, ~p[0]});
            u_sync_partner.load(8'hc3, pol);
            write_byte(8'h5a);
            tick(4);
            u_sync_partner.run(8);
            check(p_got, 8'h5a);
            read_byte(8'hc3);
            tick(30);
            u_sync_partner.run(8);
            check(p_got, 8'h5a);
            read_byte(8'h3c);
            fork
                u_sync_partner.run(8);
                write_byte(8'h81);
            join
            check(p_got, 8'h5a);
            read_byte(8'hc3);
            u_sync_partner.run(8);
            check(p_got, 8'h81);
        end
        // non-synchronous word select and mixed sources only to see the block stay idle
        for (int k = 0; k < 3; k++) begin
            start((k == 0) ? 3'h1 : WORD_SELECT_SYNC, k == 2, k == 1, 1'b0, 1'b0);
            write_byte(8'hff);
            tick(40);
            check({6'h0, sclk_oe_o, txd_oe_o}, 8'h00);
            check(8'(p_edges), 8'h00);
        end
        complete_run();
    end
endmodule
